// file: hdl/ixf_flags.sv
// ixf_flags: frame transfer interrupt flag, main bus interrupt flag and second-address match flag
// assumes the protocol engine drives the buffer flags, start, first-frame done and address, and receive indications
// on its own clock domain; they are synchronised here
`default_nettype none

// Notes on behaviour
// - frame interrupt flag, status bit 5, set when a continuous-transfer frame completes.
// - setting the frame flag also sets the main bus interrupt flag same cycle.
// - bus-format slave mode sets frame flag on buffer-flag rise only while address match set.
// - master, clocked sync and formatless modes set frame flag on every buffer-flag rise.
// - frame flag clears on writing 0 after reading it as 1; bare 0 writes ignored.
// - clearing the main interrupt flag while interface enabled also clears the frame flag.
// - slave receive, format select 0: first frame matching second address sets bit 4.
// - address match flag clears on writing 0 after reading it as 1.
// - address match flag cleared on start condition and held clear in master mode.
module ixf_flags (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic tx_buffer_empty_flag_in,
    input wire logic rx_buffer_full_flag_in,
    input wire logic start_detect_in,
    input wire logic first_frame_done_in,
    input wire logic slave_receive_in,
    input wire logic [6:0] first_frame_addr_in,
    output logic frame_xfer_irq_flag_out,
    output logic main_bus_irq_flag_out,
    output logic second_addr_match_flag_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    // third stage only feeds the edge detectors
    logic [2:0] sync3_r;
    logic [NSYNC-1:0] raw_in;
    assign raw_in = {first_frame_addr_in, slave_receive_in, first_frame_done_in,
                     rx_buffer_full_flag_in, tx_buffer_empty_flag_in};

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r[2:0];
        end
    end

    // start is a level/pulse from the bus clock; edge found after two stages
    logic start_s1_r;
    logic start_s2_r;
    logic start_s3_r;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            start_s1_r <= 1'b0;
            start_s2_r <= 1'b0;
            start_s3_r <= 1'b0;
        end else begin
            start_s1_r <= start_detect_in;
            start_s2_r <= start_s1_r;
            start_s3_r <= start_s2_r;
        end
    end

    logic tx_empty_rise;
    logic rx_full_rise;
    logic frame_done_rise;
    logic start_rise;
    logic slave_rx;
    logic [6:0] frame_addr;
    logic [2:0] pin_rise;
    for (genvar g = 0; g < 3; g++) begin : g_rise
        assign pin_rise[g] = sync2_r[g] & ~sync3_r[g];
    end
    assign tx_empty_rise = pin_rise[0];
    assign rx_full_rise = pin_rise[1];
    assign frame_done_rise = pin_rise[2];
    assign slave_rx = sync2_r[3];
    assign frame_addr = sync2_r[10:4];
    assign start_rise = start_s2_r & ~start_s3_r;

    ////////////////////////////////////////////////////////////////////////
    // control register
    logic [14:0] ctrl_r;
    logic interface_enable_bit;
    logic second_addr_format_select;
    logic [1:0] mode;
    logic [6:0] second_slave_addr_reg;
    assign interface_enable_bit = ctrl_r[ixf_pkg::ENABLE_POS];
    assign second_addr_format_select = ctrl_r[ixf_pkg::FORMAT_SEL_POS];
    assign mode = ctrl_r[ixf_pkg::MODE_LSB +: 2];
    assign second_slave_addr_reg = ctrl_r[ixf_pkg::ADDR2_LSB +: 7];

    logic master_mode;
    assign master_mode = (mode == ixf_pkg::MODE_MASTER);

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic acc;
    logic wr;
    logic rd;
    assign acc = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wr = acc & wb_we_in;
    assign rd = acc & ~wb_we_in;

    // unmapped addresses still ack and read zero
    logic wr_status;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_event;
    assign wr_status = wr & wb_sel_in[0] & (wb_adr_in == ixf_pkg::STATUS_OFFSET);
    assign wr_ctrl = wr & (wb_adr_in == ixf_pkg::CTRL_OFFSET);
    assign wr_mask = wr & wb_sel_in[0] & (wb_adr_in == ixf_pkg::MASK_OFFSET);
    assign wr_event = wr & wb_sel_in[0] & (wb_adr_in == ixf_pkg::EVENT_OFFSET);

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r <= ixf_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            if (wb_sel_in[0]) begin
                ctrl_r[7:0] <= wb_dat_in[7:0];
            end
            if (wb_sel_in[1]) begin
                ctrl_r[14:8] <= wb_dat_in[14:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags
    logic frame_flag_r;
    logic main_flag_r;
    logic addr2_flag_r;
    logic frame_seen_r;
    logic addr2_seen_r;
    logic main_seen_r;

    // read-as-one arming for the write-zero clear
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            frame_seen_r <= 1'b0;
            addr2_seen_r <= 1'b0;
            main_seen_r <= 1'b0;
        end else if (rd && wb_adr_in == ixf_pkg::STATUS_OFFSET) begin
            frame_seen_r <= frame_flag_r;
            addr2_seen_r <= addr2_flag_r;
            main_seen_r <= main_flag_r;
        end else if (wr_status) begin
            frame_seen_r <= 1'b0;
            addr2_seen_r <= 1'b0;
            main_seen_r <= 1'b0;
        end
    end

    logic frame_set;
    logic addr2_set;
    logic frame_sw_clr;
    logic addr2_sw_clr;
    logic main_sw_clr;
    logic buf_rise;
    assign buf_rise = tx_empty_rise | rx_full_rise;
    logic frame_gate;
    always_comb begin
        case (mode)
            ixf_pkg::MODE_SLAVE_BUS: frame_gate = addr2_flag_r;
            ixf_pkg::MODE_MASTER: frame_gate = 1'b1;
            ixf_pkg::MODE_CLOCKED_SYNC: frame_gate = 1'b1;
            ixf_pkg::MODE_FORMATLESS: frame_gate = 1'b1;
            default: frame_gate = 1'b1;
        endcase
    end
    assign frame_set = buf_rise & frame_gate;
    assign addr2_set = frame_done_rise & slave_rx & ~second_addr_format_select & ~master_mode
                       & (frame_addr == second_slave_addr_reg);
    assign frame_sw_clr = wr_status & frame_seen_r & ~wb_dat_in[ixf_pkg::FRAME_IRQ_POS];
    assign addr2_sw_clr = wr_status & addr2_seen_r & ~wb_dat_in[ixf_pkg::ADDR2_POS];
    // main flag sits in status bit 0 here; same read-then-write-zero clear
    assign main_sw_clr = wr_status & main_seen_r & ~wb_dat_in[ixf_pkg::MAIN_IRQ_POS];

    // set beats clear, so a frame end landing on a clear write is kept
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            main_flag_r <= 1'b0;
        end else if (frame_set) begin
            main_flag_r <= 1'b1;
        end else if (main_sw_clr) begin
            main_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            frame_flag_r <= 1'b0;
        end else if (frame_set) begin
            frame_flag_r <= 1'b1;
        end else if (frame_sw_clr || (main_sw_clr && interface_enable_bit)) begin
            frame_flag_r <= 1'b0;
        end
    end

    // start and master mode win over a match in the same cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            addr2_flag_r <= 1'b0;
        end else if (master_mode || start_rise) begin
            addr2_flag_r <= 1'b0;
        end else if (addr2_set) begin
            addr2_flag_r <= 1'b1;
        end else if (addr2_sw_clr) begin
            addr2_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt events and mask
    logic [2:0] event_r;
    logic [2:0] mask_r;
    logic [2:0] ev_set;
    // event bits mirror the flag set strobes
    assign ev_set = {frame_set, addr2_set & ~start_rise, frame_set};

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            event_r <= ixf_pkg::EVENT_RESET;
        end else begin
            event_r <= ev_set | (event_r & ~({3{wr_event}} & wb_dat_in[2:0]));
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mask_r <= ixf_pkg::MASK_RESET;
        end else if (wr_mask) begin
            mask_r <= wb_dat_in[2:0];
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(event_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs and read data
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            frame_xfer_irq_flag_out <= 1'b0;
            main_bus_irq_flag_out <= 1'b0;
            second_addr_match_flag_out <= 1'b0;
        end else begin
            frame_xfer_irq_flag_out <= frame_flag_r;
            main_bus_irq_flag_out <= main_flag_r;
            second_addr_match_flag_out <= addr2_flag_r;
        end
    end

    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        case (wb_adr_in)
            ixf_pkg::STATUS_OFFSET: begin
                rdata[ixf_pkg::FRAME_IRQ_POS] = frame_flag_r;
                rdata[ixf_pkg::ADDR2_POS] = addr2_flag_r;
                rdata[ixf_pkg::MAIN_IRQ_POS] = main_flag_r;
            end
            ixf_pkg::CTRL_OFFSET: rdata[14:0] = ctrl_r;
            ixf_pkg::MASK_OFFSET: rdata[2:0] = mask_r;
            ixf_pkg::EVENT_OFFSET: rdata[2:0] = event_r;
            default: rdata = 32'h0000_0000;
        endcase
    end

    // ack one cycle after the request is taken; the write lands at the taking edge
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= acc;
            wb_dat_out <= rd ? rdata : 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// file: include/ixf_pkg.sv
// ixf_pkg: register map, field positions and mode codes for the transfer/second-address flag block
// assumes a classic wishbone slave with 32-bit data, byte addresses
`default_nettype none
package ixf_pkg;
    localparam logic [3:0] STATUS_OFFSET = 4'h0;
    localparam logic [3:0] CTRL_OFFSET = 4'h4;
    localparam logic [3:0] MASK_OFFSET = 4'h8;
    localparam logic [3:0] EVENT_OFFSET = 4'hc;
    // status register fields
    localparam int FRAME_IRQ_POS = 5;
    localparam int ADDR2_POS = 4;
    localparam int MAIN_IRQ_POS = 0;
    // control register fields
    localparam int ENABLE_POS = 0;
    localparam int FORMAT_SEL_POS = 1;
    localparam int MODE_LSB = 2;
    localparam int ADDR2_LSB = 8;
    // event register fields (sticky, write one to clear)
    localparam int EV_FRAME_POS = 0;
    localparam int EV_ADDR2_POS = 1;
    localparam int EV_MAIN_POS = 2;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [14:0] CTRL_RESET = 15'h0000;
    localparam logic [2:0] EVENT_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [1:0] MODE_SLAVE_BUS = 2'h0;
    localparam logic [1:0] MODE_MASTER = 2'h1;
    localparam logic [1:0] MODE_CLOCKED_SYNC = 2'h2;
    localparam logic [1:0] MODE_FORMATLESS = 2'h3;
endpackage
`default_nettype wire

// file: sim/ixf_bus_peer.sv
// ixf_bus_peer: bus peers and protocol engine indications seen by the flag block
// assumes its tasks are called from the bench; paced by its own link clock
`default_nettype none
module ixf_bus_peer (
    output logic tx_empty_out,
    output logic rx_full_out,
    output logic start_out,
    output logic frame_done_out,
    output logic slave_rx_out,
    output logic [6:0] addr_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic link_clk = 1'b0;
    always #32 link_clk = ~link_clk;
    initial begin
        {tx_empty_out, rx_full_out, start_out, frame_done_out, slave_rx_out} = 5'h00;
        addr_out = 7'h2a;
    end
    task automatic start_cond();
        @(posedge link_clk) start_out <= 1'b1;
        @(posedge link_clk) start_out <= 1'b0;
    endtask
    task automatic addr_frame(input logic [6:0] a);
        @(posedge link_clk) addr_out <= a;
        slave_rx_out <= 1'b1;
        @(posedge link_clk) frame_done_out <= 1'b1;
        @(posedge link_clk) frame_done_out <= 1'b0;
        // released lines do not hold the old address
        addr_out <= ~a;
    endtask
    task automatic data_frame(input logic tx);
        @(posedge link_clk) {tx_empty_out, rx_full_out} <= {tx, !tx};
        @(posedge link_clk) {tx_empty_out, rx_full_out} <= 2'h0;
    endtask
endmodule
`default_nettype wire

// file: sim/ixf_flags_asserts.sv
// ixf_flags_asserts: port-level checks of the flag block
// assumes it is bound onto ixf_flags
`default_nettype none
module ixf_flags_chk (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic wb_ack_out,
    input wire logic tx_buffer_empty_flag_in,
    input wire logic rx_buffer_full_flag_in,
    input wire logic start_detect_in,
    input wire logic first_frame_done_in,
    input wire logic slave_receive_in,
    input wire logic frame_xfer_irq_flag_out,
    input wire logic main_bus_irq_flag_out,
    input wire logic second_addr_match_flag_out
);
    logic [1:0] mode_r;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // mode as last written by software
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) mode_r <= 2'h0;
        else if (wb_ack_out && wb_we_in && wb_sel_in[0] && wb_adr_in == ixf_pkg::CTRL_OFFSET) mode_r <= wb_dat_in[3:2];
    end
    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    ack_answer_a: assert property (s_req |=> wb_ack_out) else $error("no ack after request");
    ack_single_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held too long");
    main_follow_a: assert property ($rose(frame_xfer_irq_flag_out) |-> main_bus_irq_flag_out)
        else $error("frame flag without main flag");
    frame_cause_a: assert property ($rose(frame_xfer_irq_flag_out) |->
        $past(tx_buffer_empty_flag_in, 3) || $past(rx_buffer_full_flag_in, 3)) else $error("frame flag without cause");
    frame_clear_a: assert property ($fell(frame_xfer_irq_flag_out) |-> $past(wb_ack_out) && $past(wb_we_in))
        else $error("frame flag cleared without write");
    addr2_cause_a: assert property ($rose(second_addr_match_flag_out) |->
        $past(first_frame_done_in, 3) && $past(slave_receive_in, 3)) else $error("match flag without frame");
    addr2_start_a: assert property ($rose(start_detect_in) |-> ##[4:5] !second_addr_match_flag_out)
        else $error("match flag kept over start");
    addr2_master_a: assert property (mode_r == ixf_pkg::MODE_MASTER && $past(mode_r, 2) == ixf_pkg::MODE_MASTER
        |-> !second_addr_match_flag_out) else $error("match flag set in master mode");
endmodule
bind ixf_flags ixf_flags_chk u_chk (.*);
`default_nettype wire

// file: sim/ixf_flags_tb_top.sv
// ixf_flags_tb_top: self-checking bench for the flag block
// assumes the bus peer model and the bound checker
`default_nettype none
module ixf_flags_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
    logic [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'hf;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
    logic wb_ack_out, frame_xfer_irq_flag_out, main_bus_irq_flag_out, second_addr_match_flag_out, irq_out;
    logic tx_buffer_empty_flag_in, rx_buffer_full_flag_in, start_detect_in, first_frame_done_in, slave_receive_in;
    logic [6:0] first_frame_addr_in, a2;
    logic [1:0] cs [3] = '{2'h2, 2'h1, 2'h0};
    int n_fail = 0, num_checks = 0;
    always #2 clock_in = ~clock_in;
    ixf_flags i_dut (.*);
    ixf_bus_peer u_peer (.tx_empty_out(tx_buffer_empty_flag_in), .rx_full_out(rx_buffer_full_flag_in),
        .start_out(start_detect_in), .frame_done_out(first_frame_done_in), .slave_rx_out(slave_receive_in),
        .addr_out(first_frame_addr_in));
    task automatic conclude();
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'h3, w, a, d};
        do @(posedge clock_in); while (wb_ack_out !== 1'b1 && ++n < 20);
        if (n >= 20) n_fail++;
        q = wb_dat_out;
        {wb_cyc_in, wb_stb_in} <= 2'h0;
        @(posedge clock_in);
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic fs, input logic [6:0] a, input logic en);
        return {17'h0, a, 4'h0, m, fs, en};
    endfunction
    task automatic sts(input string nm, input logic f, input logic a);
        bus(1'b0, ixf_pkg::STATUS_OFFSET, 32'h0);
        chk(nm, {30'h0, q[5:4]}, {30'h0, f, a});
        chk({nm, " pins"}, {30'h0, frame_xfer_irq_flag_out, second_addr_match_flag_out}, {30'h0, f, a});
    endtask
    task automatic settle();
        repeat (8) @(posedge clock_in);
    endtask
    initial begin
        #100000;
        n_fail++;
        conclude();
    end
    initial begin
        void'($urandom(32'h2d2e620f));
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        bus(1'b0, ixf_pkg::STATUS_OFFSET, 32'h0);
        chk("status reset", q, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped read", q, 32'h0);
        for (int m = 1; m < 4; m++) begin
            bus(1'b1, ixf_pkg::CTRL_OFFSET, ctl(m[1:0], 1'b0, 7'h0, 1'b1));
            u_peer.data_frame(1'($urandom));
            settle();
            sts("frame set", 1'b1, 1'b0);
            chk("main set", q[0], 1'b1);
            chk("main pin", main_bus_irq_flag_out, 1'b1);
            bus(1'b1, ixf_pkg::STATUS_OFFSET, 32'h0);
            sts("read then clear", 1'b0, 1'b0);
        end
        u_peer.data_frame(1'b0);
        settle();
        bus(1'b1, ixf_pkg::STATUS_OFFSET, 32'hff);
        bus(1'b1, ixf_pkg::STATUS_OFFSET, 32'h0);
        sts("no read no clear", 1'b1, 1'b0);
        bus(1'b1, ixf_pkg::CTRL_OFFSET, ctl(2'h3, 1'b0, 7'h0, 1'b0));
        bus(1'b1, ixf_pkg::STATUS_OFFSET, 32'h20);
        sts("main clear disabled", 1'b1, 1'b0);
        chk("main cleared", q[0], 1'b0);
        bus(1'b1, ixf_pkg::CTRL_OFFSET, ctl(2'h3, 1'b0, 7'h0, 1'b1));
        u_peer.data_frame(1'($urandom));
        settle();
        sts("frame kept", 1'b1, 1'b0);
        chk("main again", q[0], 1'b1);
        bus(1'b1, ixf_pkg::STATUS_OFFSET, 32'h20);
        sts("main clear enabled", 1'b0, 1'b0);
        a2 = 7'($urandom);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, ixf_pkg::CTRL_OFFSET, ctl(2'h0, cs[i][1], a2, 1'b1));
            u_peer.data_frame(1'($urandom));
            u_peer.start_cond();
            u_peer.addr_frame(a2 ^ {6'h0, cs[i][0]});
            settle();
            sts("addr match", 1'b0, i == 2);
        end
        u_peer.data_frame(1'($urandom));
        settle();
        sts("slave frame", 1'b1, 1'b1);
        bus(1'b1, ixf_pkg::STATUS_OFFSET, 32'h0);
        sts("both cleared", 1'b0, 1'b0);
        u_peer.start_cond();
        u_peer.addr_frame(a2);
        settle();
        sts("match before start", 1'b0, 1'b1);
        u_peer.start_cond();
        settle();
        sts("start clears match", 1'b0, 1'b0);
        u_peer.addr_frame(a2);
        settle();
        sts("match before master", 1'b0, 1'b1);
        bus(1'b1, ixf_pkg::CTRL_OFFSET, ctl(2'h1, 1'b0, a2, 1'b1));
        settle();
        sts("master clears match", 1'b0, 1'b0);
        bus(1'b1, ixf_pkg::EVENT_OFFSET, 32'h7);
        bus(1'b1, ixf_pkg::MASK_OFFSET, 32'h1);
        u_peer.data_frame(1'b1);
        settle();
        chk("irq raised", irq_out, 1'b1);
        bus(1'b0, ixf_pkg::EVENT_OFFSET, 32'h0);
        chk("events", q, 32'h5);
        bus(1'b1, ixf_pkg::MASK_OFFSET, 32'h2);
        chk("irq masked", irq_out, 1'b0);
        bus(1'b1, ixf_pkg::MASK_OFFSET, 32'h1);
        bus(1'b1, ixf_pkg::EVENT_OFFSET, 32'h1);
        chk("irq cleared", irq_out, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
